/* File: pkg/rmpr_pkg.sv */
// rmpr_pkg: offsets, field positions and reset values of receive profiles 1 to 3
// assumes 8-bit registers on a 10-bit internal register address
package rmpr_pkg;

    localparam int RMPR_AW = 10;
    localparam int RMPR_NREG = 8;

    // register offsets, index order used throughout the bank
    localparam logic [9:0] RMPR_P1_EN_OFF = 10'h043;
    localparam logic [9:0] RMPR_P1_GA_OFF = 10'h044;
    localparam logic [9:0] RMPR_P1_GB_OFF = 10'h045;
    localparam logic [9:0] RMPR_P2_EN_OFF = 10'h046;
    localparam logic [9:0] RMPR_P2_GA_OFF = 10'h047;
    localparam logic [9:0] RMPR_P2_GB_OFF = 10'h048;
    localparam logic [9:0] RMPR_P3_EN_OFF = 10'h049;
    localparam logic [9:0] RMPR_P3_GA_OFF = 10'h04a;
    localparam logic [9:0] RMPR_STATUS_OFF = 10'h032;

    // register indices
    localparam int RMPR_P1_EN = 0;
    localparam int RMPR_P1_GA = 1;
    localparam int RMPR_P1_GB = 2;
    localparam int RMPR_P2_EN = 3;
    localparam int RMPR_P2_GA = 4;
    localparam int RMPR_P2_GB = 5;
    localparam int RMPR_P3_EN = 6;
    localparam int RMPR_P3_GA = 7;

    // path-enable layout: [6] splitter one, [5] ch1ch2, [4] ch3ch4, [3:0] channels 1..4
    localparam int RMPR_SPLIT_LSB = 4;
    localparam int RMPR_CHAN_LSB = 0;
    // gain layout: high field [6:4], low field [2:0]
    localparam int RMPR_GAIN_HI_LSB = 4;
    localparam int RMPR_GAIN_LO_LSB = 0;
    localparam logic [3:0] RMPR_STATUS_PROFILE_LSB = 4'h0;

    // writable bits; reserved bits read as zero
    localparam logic [7:0] RMPR_EN_MASK = 8'h7f;
    localparam logic [7:0] RMPR_GAIN_MASK = 8'h77;

    // values after reset
    localparam logic [7:0] RMPR_P1_EN_RST = 8'h68;
    localparam logic [7:0] RMPR_P2_EN_RST = 8'h64;
    localparam logic [7:0] RMPR_P3_EN_RST = 8'h52;
    localparam logic [7:0] RMPR_GAIN_RST = 8'h77;
    localparam logic [2:0] RMPR_LEVEL_RST = 3'h7;
    localparam logic [3:0] RMPR_PROFILE_RST = 4'h0;

    localparam logic [9:0] RMPR_OFFS [RMPR_NREG] = '{
        RMPR_P1_EN_OFF, RMPR_P1_GA_OFF, RMPR_P1_GB_OFF, RMPR_P2_EN_OFF,
        RMPR_P2_GA_OFF, RMPR_P2_GB_OFF, RMPR_P3_EN_OFF, RMPR_P3_GA_OFF};
    localparam logic [7:0] RMPR_RSTS [RMPR_NREG] = '{
        RMPR_P1_EN_RST, RMPR_GAIN_RST, RMPR_GAIN_RST, RMPR_P2_EN_RST,
        RMPR_GAIN_RST, RMPR_GAIN_RST, RMPR_P3_EN_RST, RMPR_GAIN_RST};
    localparam logic [7:0] RMPR_MASKS [RMPR_NREG] = '{
        RMPR_EN_MASK, RMPR_GAIN_MASK, RMPR_GAIN_MASK, RMPR_EN_MASK,
        RMPR_GAIN_MASK, RMPR_GAIN_MASK, RMPR_EN_MASK, RMPR_GAIN_MASK};

    localparam logic [3:0] RMPR_PROFILE_ONE = 4'h1;
    localparam logic [3:0] RMPR_PROFILE_TWO = 4'h2;
    localparam logic [3:0] RMPR_PROFILE_THREE = 4'h3;

endpackage : rmpr_pkg

/* File: verilog/rmpr_reg8.sv */
// rmpr_reg8: one 8-bit profile register with a reset value and a writable-bit mask
// assumes write strobe and data are synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module rmpr_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // write side
    input wire logic wr_in,
    input wire logic [7:0] data_in,
    // stored value
    output logic [7:0] q_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_out <= RST_VAL;
        end else if (wr_in) begin
            // reserved bits never take a one
            q_out <= data_in & WR_MASK;
        end
    end
endmodule : rmpr_reg8
`default_nettype wire

/* File: verilog/rmpr_profile_bank.sv */
// rmpr_profile_bank: stored receive profiles 1..3 and the applied-profile outputs
// assumes an external serial port slave turns transfers into single-cycle strobes
// Notes on behaviour
// [R1] profile 1 enables reset to splitter one, ch1ch2 splitter, channel 1 on
// [R2] profile 1 gains: ch1/ch3 in [6:4], ch2/ch4 in [2:0], reset 0x7
// [R3] profile 2 enables reset to splitter one, ch1ch2 splitter, channel 2 on
// [R4] profile 2 gains same layout at 0x047/0x048, writable, reset 0x7
// [R5] profile 3 enables reset to splitter one, ch3ch4 splitter, channel 3 on
// [R6] profile 3 ch1/ch2 gains at 0x04a, writable 3-bit fields, reset 0x7
// [R7] applied profile number readable as 4-bit read-only status field
// [R8] selected profile's enables and gains drive the channel and splitter controls
`timescale 1ns/1ps
`default_nettype none
module rmpr_profile_bank
    import rmpr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register access from the serial port slave
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [RMPR_AW-1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out,
    // sequencer profile selection
    input wire logic seq_load_in,
    input wire logic [3:0] seq_profile_in,
    // applied controls
    output logic [3:0] applied_receive_profile_out,
    output logic [2:0] splitter_on_out,
    output logic [3:0] chan_on_out,
    output logic [11:0] chan_level_out
);
    logic [7:0] reg_q [RMPR_NREG];
    logic [RMPR_NREG-1:0] hit;
    logic [7:0] rd_next;
    logic [7:0] en_next;
    logic [11:0] level_next;

    genvar gi;
    generate
        for (gi = 0; gi < RMPR_NREG; gi++) begin : g_regs
            assign hit[gi] = (addr_in == RMPR_OFFS[gi]);
            rmpr_reg8 #(
                .RST_VAL(RMPR_RSTS[gi]),
                .WR_MASK(RMPR_MASKS[gi])
            ) u_reg (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .wr_in(wr_en_in & hit[gi]), // R1 R2 R3 R4 R5 R6
                .data_in(wr_data_in),
                .q_out(reg_q[gi])
            );
        end
    endgenerate

    // the status register is read-only; writes to it are dropped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            applied_receive_profile_out <= RMPR_PROFILE_RST;
        end else if (seq_load_in) begin
            applied_receive_profile_out <= seq_profile_in; // R7
        end
    end

    always_comb begin
        rd_next = 8'h00;
        if (addr_in == RMPR_STATUS_OFF) begin
            // sequencer count field is outside this bank and reads zero
            rd_next = 8'({applied_receive_profile_out} << RMPR_STATUS_PROFILE_LSB); // R7
        end
        for (int i = 0; i < RMPR_NREG; i++) begin
            if (hit[i]) begin
                rd_next = reg_q[i];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= rd_next;
        end
    end

    // profiles outside 1..3 live elsewhere; here they park every path off
    always_comb begin
        en_next = 8'h00;
        level_next = {4{RMPR_LEVEL_RST}};
        case (applied_receive_profile_out)
            RMPR_PROFILE_ONE: begin
                en_next = reg_q[RMPR_P1_EN];
                level_next = {reg_q[RMPR_P1_GA][6:4], reg_q[RMPR_P1_GA][2:0],
                              reg_q[RMPR_P1_GB][6:4], reg_q[RMPR_P1_GB][2:0]};
            end
            RMPR_PROFILE_TWO: begin
                en_next = reg_q[RMPR_P2_EN];
                level_next = {reg_q[RMPR_P2_GA][6:4], reg_q[RMPR_P2_GA][2:0],
                              reg_q[RMPR_P2_GB][6:4], reg_q[RMPR_P2_GB][2:0]};
            end
            RMPR_PROFILE_THREE: begin
                // channel 3/4 gains of this profile are not held here
                en_next = reg_q[RMPR_P3_EN];
                level_next = {reg_q[RMPR_P3_GA][6:4], reg_q[RMPR_P3_GA][2:0],
                              RMPR_LEVEL_RST, RMPR_LEVEL_RST};
            end
            default: begin
                en_next = 8'h00;
                level_next = {4{RMPR_LEVEL_RST}};
            end
        endcase
    end

    // registered so a profile switch changes all controls on the same edge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            splitter_on_out <= 3'h0;
            chan_on_out <= 4'h0;
            chan_level_out <= {4{RMPR_LEVEL_RST}};
        end else begin
            splitter_on_out <= en_next[RMPR_SPLIT_LSB +: 3]; // R8
            chan_on_out <= en_next[RMPR_CHAN_LSB +: 4]; // R8
            chan_level_out <= level_next; // R8
        end
    end

    chk_p1_en_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        $past(rst_in) |-> reg_q[RMPR_P1_EN] == 8'h68)
        else $error("profile 1 enables wrong after reset");
    chk_p1_gain_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        $past(rst_in) |-> (reg_q[RMPR_P1_GA] == 8'h77 && reg_q[RMPR_P1_GB] == 8'h77))
        else $error("profile 1 gains wrong after reset");
    chk_p2_en_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        $past(rst_in) |-> reg_q[RMPR_P2_EN] == 8'h64)
        else $error("profile 2 enables wrong after reset");
    chk_p2_gain_write: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        (wr_en_in && addr_in == 10'h048) |=> reg_q[RMPR_P2_GB] == ($past(wr_data_in) & 8'h77))
        else $error("profile 2 gain write not stored");
    chk_p3_en_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        $past(rst_in) |-> reg_q[RMPR_P3_EN] == 8'h52)
        else $error("profile 3 enables wrong after reset");
    chk_p3_gain_read: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        (wr_en_in && addr_in == 10'h04a) ##1 (rd_en_in && addr_in == 10'h04a && !wr_en_in)
        |=> rd_data_out == ($past(wr_data_in, 2) & 8'h77))
        else $error("profile 3 gain readback wrong");
    chk_status_profile: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        seq_load_in ##1 (rd_en_in && addr_in == 10'h032 && !seq_load_in)
        |=> rd_data_out == {4'h0, $past(seq_profile_in, 2)})
        else $error("status does not show applied profile");
    // a second load or a write in the settling cycles legally moves the outputs on
    chk_apply_controls: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        (seq_load_in && seq_profile_in == 4'h2) ##1 (!seq_load_in && !wr_en_in) ##1 !wr_en_in
        |-> ({splitter_on_out, chan_on_out} == reg_q[RMPR_P2_EN][6:0]
             && chan_level_out[11:9] == reg_q[RMPR_P2_GA][6:4])[*2])
        else $error("applied controls do not follow profile 2");

    // every profile register keeps exactly the writable bits of the last write
    chk_p1_en_write: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        (wr_en_in && addr_in == RMPR_P1_EN_OFF)
        |=> reg_q[RMPR_P1_EN] == ($past(wr_data_in) & RMPR_EN_MASK))
        else $error("profile 1 enable write not stored");
    chk_p1_ga_write: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        (wr_en_in && addr_in == RMPR_P1_GA_OFF)
        |=> reg_q[RMPR_P1_GA] == ($past(wr_data_in) & RMPR_GAIN_MASK))
        else $error("profile 1 channel 1/2 gain write not stored");
    chk_p1_gb_write: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        (wr_en_in && addr_in == RMPR_P1_GB_OFF)
        |=> reg_q[RMPR_P1_GB] == ($past(wr_data_in) & RMPR_GAIN_MASK))
        else $error("profile 1 channel 3/4 gain write not stored");
    chk_p2_en_write: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        (wr_en_in && addr_in == RMPR_P2_EN_OFF)
        |=> reg_q[RMPR_P2_EN] == ($past(wr_data_in) & RMPR_EN_MASK))
        else $error("profile 2 enable write not stored");
    chk_p2_ga_write: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        (wr_en_in && addr_in == RMPR_P2_GA_OFF)
        |=> reg_q[RMPR_P2_GA] == ($past(wr_data_in) & RMPR_GAIN_MASK))
        else $error("profile 2 channel 1/2 gain write not stored");
    chk_p3_en_write: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        (wr_en_in && addr_in == RMPR_P3_EN_OFF)
        |=> reg_q[RMPR_P3_EN] == ($past(wr_data_in) & RMPR_EN_MASK))
        else $error("profile 3 enable write not stored");
    chk_p3_ga_write: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        (wr_en_in && addr_in == RMPR_P3_GA_OFF)
        |=> reg_q[RMPR_P3_GA] == ($past(wr_data_in) & RMPR_GAIN_MASK))
        else $error("profile 3 gain write not stored");

    chk_p2_gain_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        $past(rst_in)
        |-> (reg_q[RMPR_P2_GA] == RMPR_GAIN_RST && reg_q[RMPR_P2_GB] == RMPR_GAIN_RST))
        else $error("profile 2 gains wrong after reset");
    chk_p3_gain_reset: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        $past(rst_in) |-> reg_q[RMPR_P3_GA] == RMPR_GAIN_RST)
        else $error("profile 3 gains wrong after reset");
    chk_unmapped_read: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        (rd_en_in && addr_in == 10'h04b) |=> rd_data_out == 8'h00)
        else $error("address outside the bank does not read zero");

    // only the sequencer moves the applied profile; status writes are dropped
    chk_status_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        !seq_load_in |=> $stable(applied_receive_profile_out))
        else $error("applied profile changed without a sequencer load");

    chk_p1_controls: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        $past(applied_receive_profile_out) == RMPR_PROFILE_ONE
        |-> ({splitter_on_out, chan_on_out} == $past(reg_q[RMPR_P1_EN][6:0])
             && chan_level_out[5:3] == $past(reg_q[RMPR_P1_GB][6:4])
             && chan_level_out[2:0] == $past(reg_q[RMPR_P1_GB][2:0])))
        else $error("applied controls do not follow profile 1");
    // channel 3/4 gains of profile 3 are held elsewhere and park at the reset level
    chk_p3_ch34_parked: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        $past(applied_receive_profile_out) == RMPR_PROFILE_THREE
        |-> chan_level_out[5:0] == {2{RMPR_LEVEL_RST}})
        else $error("profile 3 channel 3/4 gains not parked");
    chk_other_profile_off: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        ($past(applied_receive_profile_out) == RMPR_PROFILE_RST
         || $past(applied_receive_profile_out) > RMPR_PROFILE_THREE)
        |-> (splitter_on_out == 3'h0 && chan_on_out == 4'h0
             && chan_level_out == {4{RMPR_LEVEL_RST}}))
        else $error("profile outside this bank does not park every path");

    cov_switch_p3: cover property (@(posedge clk_in) disable iff (rst_in)
        seq_load_in && seq_profile_in == 4'h3);
    cov_write_p1: cover property (@(posedge clk_in) disable iff (rst_in)
        wr_en_in && addr_in == 10'h043);
    cov_read_status: cover property (@(posedge clk_in) disable iff (rst_in)
        rd_en_in && addr_in == 10'h032 && applied_receive_profile_out != 4'h0);
    cov_load_then_status: cover property (@(posedge clk_in) disable iff (rst_in)
        seq_load_in ##1 (rd_en_in && addr_in == RMPR_STATUS_OFF));
    cov_other_profile: cover property (@(posedge clk_in) disable iff (rst_in)
        seq_load_in && seq_profile_in > RMPR_PROFILE_THREE);

endmodule : rmpr_profile_bank
`default_nettype wire

/* File: verif/test_rx_mode_profile_regs_1_to_3.sv */
// test_rx_mode_profile_regs_1_to_3: self-checking bench for the receive profile bank
// assumes the bench drives the strobe port directly at falling edges; no serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module test_rx_mode_profile_regs_1_to_3 import rmpr_pkg::*;;
    logic clk_in, rst_in, wr_en_in, rd_en_in, seq_load_in;
    logic [RMPR_AW-1:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out;
    logic [3:0] seq_profile_in, applied, chan;
    logic [2:0] splitter;
    logic [11:0] level;
    int failures = 0;
    int cmp_count = 0;

    rmpr_profile_bank DUT (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .rd_data_out(rd_data_out), .seq_load_in(seq_load_in), .seq_profile_in(seq_profile_in),
        .applied_receive_profile_out(applied), .splitter_on_out(splitter),
        .chan_on_out(chan), .chan_level_out(level));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic do_reset();
        @(negedge clk_in);
        rst_in = 1'b1;
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
    endtask : do_reset

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_en_in = 1'b1;
        addr_in = a;
        wr_data_in = d;
        @(negedge clk_in);
        wr_en_in = 1'b0;
    endtask : wr

    // read data is registered, so it is judged one cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        rd_en_in = 1'b1;
        addr_in = a;
        @(negedge clk_in);
        rd_en_in = 1'b0;
        `CHK("rd_data", exp, rd_data_out)
    endtask : rd

    task automatic sel(input logic [3:0] p, input logic [2:0] sp, input logic [3:0] ch,
                       input logic [11:0] lv);
        @(negedge clk_in);
        seq_load_in = 1'b1;
        seq_profile_in = p;
        @(negedge clk_in);
        seq_load_in = 1'b0;
        `CHK("applied", p, applied)
        @(negedge clk_in);
        `CHK("splitter", sp, splitter)
        `CHK("chan_on", ch, chan)
        `CHK("level", lv, level)
    endtask : sel

    task automatic test_reset();
        `CHK("applied_rst", 4'h0, applied)
        rd(10'h043, 8'h68);
        rd(10'h044, 8'h77);
        rd(10'h045, 8'h77);
        rd(10'h046, 8'h64);
        rd(10'h047, 8'h77);
        rd(10'h048, 8'h77);
        rd(10'h049, 8'h52);
        rd(10'h04a, 8'h77);
        rd(10'h032, 8'h00);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_select();
        sel(4'h1, 3'b110, 4'b1000, 12'hfff);
        rd(10'h032, 8'h01);
        sel(4'h2, 3'b110, 4'b0100, 12'hfff);
        sel(4'h3, 3'b101, 4'b0010, 12'hfff);
        wr(10'h032, 8'hff);
        rd(10'h032, 8'h03);
        // profiles outside this bank leave every path off
        sel(4'ha, 3'b000, 4'b0000, 12'hfff);
        $display("test_select done");
    endtask : test_select

    task automatic test_write();
        for (int i = 0; i < 8; i++) begin
            wr(10'(10'h043 + i), 8'hff);
            rd(10'(10'h043 + i), (i % 3 == 0) ? 8'h7f : 8'h77);
        end
        rd(10'h04b, 8'h00);
        sel(4'h1, 3'b111, 4'b1111, 12'hfff);
        // a write to the applied profile must reach the outputs without a new select
        wr(10'h044, 8'h25);
        wr(10'h043, 8'h00);
        @(negedge clk_in);
        `CHK("level_live", 12'h57f, level)
        `CHK("chan_live", 4'h0, chan)
        wr(10'h04a, 8'h8a);
        rd(10'h04a, 8'h02);
        sel(4'h3, 3'b111, 4'b1111, 12'h0bf);
        $display("test_write done");
    endtask : test_write

    // strobes on consecutive edges: a read right after a write, a status read right after a load
    task automatic test_back_to_back();
        @(negedge clk_in);
        wr_en_in = 1'b1;
        addr_in = 10'h04a;
        wr_data_in = 8'h5d;
        @(negedge clk_in);
        wr_en_in = 1'b0;
        rd_en_in = 1'b1;
        @(negedge clk_in);
        rd_en_in = 1'b0;
        `CHK("rd_b2b_gain", 8'h55, rd_data_out)
        seq_load_in = 1'b1;
        seq_profile_in = 4'h2;
        @(negedge clk_in);
        seq_load_in = 1'b0;
        rd_en_in = 1'b1;
        addr_in = 10'h032;
        @(negedge clk_in);
        rd_en_in = 1'b0;
        `CHK("rd_b2b_status", 8'h02, rd_data_out)
        @(negedge clk_in);
        `CHK("splitter_b2b", 3'b111, splitter)
        `CHK("chan_b2b", 4'hf, chan)
        `CHK("level_b2b", 12'hfff, level)
        $display("test_back_to_back done");
    endtask : test_back_to_back

    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        print_verdict();
    end

    initial begin
        rst_in = 1'b1;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        seq_load_in = 1'b0;
        seq_profile_in = 4'h0;
        addr_in = '0;
        wr_data_in = 8'h00;
        do_reset();
        test_reset();
        test_select();
        test_write();
        test_back_to_back();
        // a second reset in mid-run must restore every stored default
        do_reset();
        test_reset();
        print_verdict();
    end
endmodule : test_rx_mode_profile_regs_1_to_3
`default_nettype wire
